// ### umc_bit_timer.sv
// One-shot timer that pulses once a bit time after it is started.
`timescale 1ns/1ns
module umc_bit_timer #(
  parameter int CYCLES = 1042
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Control
  input wire logic i_start,
  input wire logic i_abort,
  // Status
  output logic o_done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] count_reg;
  logic busy_reg;
  logic done_reg;

  wire finish = busy_reg && !i_abort && count_reg == LAST;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= finish;
      if (i_abort || finish) begin
        busy_reg <= 1'b0;
        count_reg <= '0;
      end else if (i_start) begin
        busy_reg <= 1'b1;
        count_reg <= CW'(1);
      end else if (busy_reg) begin
        count_reg <= count_reg + CW'(1);
      end
    end
  end

  assign o_done = done_reg;

endmodule

// ### umc_mode_config.sv
// Mode registers, thresholds, flow control and error status of one channel.
//
// Overview of operation
// R1: 8-byte depth: receive interrupt at 1, 6, 4 or 8 bytes held per code.
// R2: 16-byte depth: receive interrupt at 1, 8, 12 or 16 bytes held per code.
// R3: Receive FIFO empty after reset; default code interrupts at one byte held.
// R4: 8-byte depth: transmit interrupt at 8, 4, 6 or 1 free positions per code.
// R5: 16-byte depth: transmit interrupt at 16, 8, 12 or 1 free positions per code.
// R6: Default transmit code interrupts when enabled and empty, drops on first byte loaded.
// R7: FIFO depth bit selects 8 or 16 bytes for both threshold tables.
// R8: Baud group codes 000, 001 and 100 only; other codes must not be written.
// R9: Pointer starts at mode_reg_1; any mode_reg_1 access moves it to mode_reg_2.
// R10: Character error mode shows top character; block mode ORs since error reset.
// R11: Block error status clears only on error reset command or receiver reset.
// R12: Receiver flow control negates request-to-send on start bit while full.
// R13: Start of a character beyond capacity flags overrun and discards it.
// R14: Software sets output_reg bit 0 for receiver flow control to work.
// R15: Parity mode selects with, forced, none or multi-drop parity handling.
// R16: Parity type selects even/odd, forced value or address bit polarity.
// R17: Character length codes select 5 to 8 data bits.
// R18: Stop length codes map to sixteenths, plus half a bit for 5-bit characters on codes 0 to 7.
// R19: Channel mode selects normal, echo, local loop or remote loop.
// R20: With clear-to-send enabled, characters start only while that input is low.
// R21: Transmitter auto control clears output_reg bit 0 a bit time after draining.
// R22: Threshold interrupts are levels recomputed every clock from occupancy.
`timescale 1ns/1ns
module umc_mode_config import umc_pkg::*; #(
  parameter int BIT_CYCLES_P = BIT_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Host register port
  input wire logic [3:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // FIFO and line state from the data path
  input wire logic [4:0] i_rx_count,
  input wire logic [4:0] i_tx_count,
  input wire logic i_tx_idle,
  input wire logic i_rx_start,
  input wire logic i_top_advance,
  input wire logic i_top_framing_err,
  input wire logic i_top_parity_err,
  input wire logic i_top_break,
  input wire logic i_clear_to_send_in_n,
  // Interrupt requests and line control
  output logic o_rx_int,
  output logic o_tx_int,
  output logic o_request_to_send_out_n,
  output logic o_tx_send_ok,
  output logic o_rx_discard,
  output logic [7:0] o_output_reg,
  // Channel control
  output logic o_rx_enable,
  output logic o_tx_enable,
  output logic o_rx_reset,
  output logic o_tx_reset,
  // Character format
  output logic [1:0] o_char_bits,
  output logic [1:0] o_parity_mode,
  output logic o_parity_type,
  output logic o_parity_on,
  output logic [5:0] o_stop_sixteenths,
  output logic [1:0] o_channel_mode,
  output logic [1:0] o_baud_sel,
  output logic o_fifo_16
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] rx_level(input logic [1:0] code, input logic deep);
    case (code)
      2'h0: rx_level = 5'h01;
      2'h1: rx_level = deep ? 5'h08 : 5'h06;
      2'h2: rx_level = deep ? 5'h0C : 5'h04;
      default: rx_level = deep ? DEPTH_LARGE : DEPTH_SMALL;
    endcase
  endfunction

  function automatic logic [4:0] tx_level(input logic [1:0] code, input logic deep);
    case (code)
      2'h0: tx_level = deep ? DEPTH_LARGE : DEPTH_SMALL;
      2'h1: tx_level = deep ? 5'h08 : 5'h04;
      2'h2: tx_level = deep ? 5'h0C : 5'h06;
      default: tx_level = 5'h01;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mode0_reg, mode1_reg, mode2_reg, opr_reg, rdata_reg;
  umc_ptr_t ptr_reg;
  logic rx_en_reg, tx_en_reg, rx_reset_reg, tx_reset_reg;
  logic cts_meta_reg, cts_sync_reg, send_ok_reg;
  logic [2:0] top_err_reg, err_acc_reg;
  logic overrun_reg, beyond_reg, discard_reg;
  logic rx_int_reg, tx_int_reg, rts_n_reg, armed_reg;
  logic [5:0] stop_reg;
  logic [1:0] baud_sel_reg;
  logic parity_on_reg;
  logic timer_done;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire mode_wr = i_wr_en && i_addr == ADDR_MODE;
  wire mode_rd = i_rd_en && i_addr == ADDR_MODE;
  wire cmd_wr = i_wr_en && i_addr == ADDR_COMMAND;
  wire set_wr = i_wr_en && i_addr == ADDR_OUT_SET;
  wire clr_wr = i_wr_en && i_addr == ADDR_OUT_CLR;
  wire [3:0] cmd_code = i_wdata[7:4];
  wire cmd_ptr1 = cmd_wr && cmd_code == CMD_PTR_MR1;
  wire cmd_ptr0 = cmd_wr && cmd_code == CMD_PTR_MR0;
  wire cmd_rx_rst = cmd_wr && cmd_code == CMD_RX_RESET;
  wire cmd_tx_rst = cmd_wr && cmd_code == CMD_TX_RESET;
  wire err_clear = (cmd_wr && cmd_code == CMD_ERR_RESET) || cmd_rx_rst; // R11
  wire deep = mode0_reg[MR0_FIFO_BIT]; // R7
  wire [4:0] depth = deep ? DEPTH_LARGE : DEPTH_SMALL; // R7
  wire rx_full = i_rx_count >= depth;
  wire [4:0] tx_free = (i_tx_count >= depth) ? 5'h00 : depth - i_tx_count;
  wire [1:0] rx_code = {mode0_reg[MR0_RXINT_BIT], mode1_reg[MR1_RXINT_BIT]};
  wire [1:0] tx_code = mode0_reg[MR0_TXINT_LO +: 2];
  wire rx_int_next = i_rx_count >= rx_level(rx_code, deep); // R1 R2 R3 R22
  wire tx_int_next = tx_en_reg && tx_free >= tx_level(tx_code, deep); // R4 R5 R6 R22
  wire [2:0] top_in = {i_top_break, i_top_framing_err, i_top_parity_err};
  wire [2:0] err_shown = mode1_reg[MR1_ERRMODE_BIT] ? err_acc_reg : top_err_reg; // R10
  wire [2:0] err_acc_next = (i_top_advance ? top_in : 3'h0) | (err_clear ? 3'h0 : err_acc_reg); // R10 R11
  wire discard_next = i_rx_start && rx_full && beyond_reg; // R13
  wire beyond_next = !cmd_rx_rst && rx_full && (beyond_reg || i_rx_start);
  wire auto_rts = mode2_reg[MR2_TXRTS_BIT] && !tx_en_reg && i_tx_idle && opr_reg[0]; // R21
  wire timer_start = auto_rts && !armed_reg;
  wire [7:0] opr_cleared = (timer_done && auto_rts) ? (opr_reg & 8'hFE) : opr_reg; // R21
  wire [7:0] opr_next = (opr_cleared & ~(clr_wr ? i_wdata : 8'h00)) | (set_wr ? i_wdata : 8'h00);
  wire rts_hold = mode1_reg[MR1_RXRTS_BIT] && beyond_next; // R12 R14
  wire rts_n_next = !(opr_next[0] && !rts_hold); // R12
  wire [3:0] stop_code = mode2_reg[MR2_STOP_LO +: 4];
  wire [5:0] stop_short = STOP_BASE_SHORT + {2'h0, stop_code} +
    ((mode1_reg[MR1_LEN_LO +: 2] == LEN_FIVE) ? STOP_HALF_BIT : 6'h00);
  wire [5:0] stop_next = stop_code[3] ? (STOP_BASE_LONG + {2'h0, stop_code}) : stop_short; // R18
  wire [1:0] par_mode = mode1_reg[MR1_PAR_LO +: 2];
  wire parity_on_next = par_mode == PAR_WITH || par_mode == PAR_FORCE; // R15
  wire [2:0] baud_code = mode0_reg[MR0_BAUD_LO +: 3];
  wire [1:0] baud_sel_next = (baud_code == BAUD_EXT1) ? BAUD_SEL_EXT1 :
    (baud_code == BAUD_EXT2) ? BAUD_SEL_EXT2 : BAUD_SEL_NORMAL; // R8
  wire [7:0] status = {err_shown, overrun_reg, i_tx_idle, tx_en_reg && tx_free != 5'h00,
    rx_full, i_rx_count != 5'h00};

  umc_ptr_t ptr_next;
  logic [7:0] mode_rdata;
  always_comb begin
    ptr_next = ptr_reg;
    mode_rdata = mode2_reg;
    case (ptr_reg)
      UMC_PTR_MR0: begin
        mode_rdata = mode0_reg;
        if (mode_wr || mode_rd) begin
          ptr_next = UMC_PTR_MR1;
        end
      end
      UMC_PTR_MR1: begin
        mode_rdata = mode1_reg;
        if (mode_wr || mode_rd) begin
          ptr_next = UMC_PTR_MR2; // R9
        end
      end
      default: begin
        mode_rdata = mode2_reg;
      end
    endcase
    if (cmd_ptr1) begin
      ptr_next = UMC_PTR_MR1; // R9
    end else if (cmd_ptr0) begin
      ptr_next = UMC_PTR_MR0;
    end
  end

  wire [7:0] rdata_next = !i_rd_en ? rdata_reg : (i_addr == ADDR_MODE) ? mode_rdata :
    (i_addr == ADDR_STATUS) ? status : 8'h00;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      mode0_reg <= MODE_REG_RESET;
      mode1_reg <= MODE_REG_RESET;
      mode2_reg <= MODE_REG_RESET;
      ptr_reg <= UMC_PTR_MR1;
    end else begin
      ptr_reg <= ptr_next;
      if (mode_wr && ptr_reg == UMC_PTR_MR0) begin
        mode0_reg <= i_wdata;
      end
      if (mode_wr && ptr_reg == UMC_PTR_MR1) begin
        mode1_reg <= i_wdata;
      end
      if (mode_wr && ptr_reg == UMC_PTR_MR2) begin
        mode2_reg <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      rx_reset_reg <= 1'b0;
      tx_reset_reg <= 1'b0;
      opr_reg <= OUT_REG_RESET;
      rdata_reg <= 8'h00;
    end else begin
      rx_reset_reg <= cmd_rx_rst;
      tx_reset_reg <= cmd_tx_rst;
      if (cmd_rx_rst || (cmd_wr && i_wdata[CMD_RX_DIS_BIT])) begin
        rx_en_reg <= 1'b0;
      end else if (cmd_wr && i_wdata[CMD_RX_EN_BIT]) begin
        rx_en_reg <= 1'b1;
      end
      if (cmd_tx_rst || (cmd_wr && i_wdata[CMD_TX_DIS_BIT])) begin
        tx_en_reg <= 1'b0;
      end else if (cmd_wr && i_wdata[CMD_TX_EN_BIT]) begin
        tx_en_reg <= 1'b1;
      end
      opr_reg <= opr_next;
      rdata_reg <= rdata_next;
    end
  end

  // The clear-to-send pin is asynchronous, so only the second stage is read.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cts_meta_reg <= 1'b1;
      cts_sync_reg <= 1'b1;
      send_ok_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      cts_meta_reg <= i_clear_to_send_in_n;
      cts_sync_reg <= cts_meta_reg;
      send_ok_reg <= !mode2_reg[MR2_CTS_BIT] || !cts_sync_reg; // R20
      armed_reg <= auto_rts;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      top_err_reg <= 3'h0;
      err_acc_reg <= 3'h0;
      overrun_reg <= 1'b0;
      beyond_reg <= 1'b0;
      discard_reg <= 1'b0;
      rx_int_reg <= 1'b0;
      tx_int_reg <= 1'b0;
      rts_n_reg <= 1'b1;
      stop_reg <= STOP_BASE_SHORT;
      baud_sel_reg <= BAUD_SEL_NORMAL;
      parity_on_reg <= 1'b1;
    end else begin
      top_err_reg <= top_in;
      err_acc_reg <= err_acc_next;
      overrun_reg <= discard_next || (overrun_reg && !err_clear); // R13
      beyond_reg <= beyond_next;
      discard_reg <= discard_next;
      rx_int_reg <= rx_int_next;
      tx_int_reg <= tx_int_next;
      rts_n_reg <= rts_n_next;
      stop_reg <= stop_next;
      baud_sel_reg <= baud_sel_next;
      parity_on_reg <= parity_on_next;
    end
  end

  umc_bit_timer #(
    .CYCLES(BIT_CYCLES_P)
  ) u_turnaround (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_start(timer_start),
    .i_abort(!auto_rts),
    .o_done(timer_done)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_rx_int = rx_int_reg;
  assign o_tx_int = tx_int_reg;
  assign o_request_to_send_out_n = rts_n_reg;
  assign o_tx_send_ok = send_ok_reg;
  assign o_rx_discard = discard_reg;
  assign o_output_reg = opr_reg;
  assign o_rx_enable = rx_en_reg;
  assign o_tx_enable = tx_en_reg;
  assign o_rx_reset = rx_reset_reg;
  assign o_tx_reset = tx_reset_reg;
  assign o_char_bits = mode1_reg[MR1_LEN_LO +: 2]; // R17
  assign o_parity_mode = mode1_reg[MR1_PAR_LO +: 2]; // R15
  assign o_parity_type = mode1_reg[MR1_PTYPE_BIT]; // R16
  assign o_parity_on = parity_on_reg;
  assign o_stop_sixteenths = stop_reg;
  assign o_channel_mode = mode2_reg[MR2_CHMODE_LO +: 2]; // R19
  assign o_baud_sel = baud_sel_reg;
  assign o_fifo_16 = mode0_reg[MR0_FIFO_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RX_SMALL_FOUR: assert property (@(posedge i_clock) disable iff (!i_rstn) // R1
    (!deep && rx_code == 2'h2 && i_rx_count >= 5'h04) |=> o_rx_int)
    else $error("Receive interrupt missing at four bytes with small FIFO.");
  AST_RX_LARGE_EIGHT: assert property (@(posedge i_clock) disable iff (!i_rstn) // R2
    (deep && rx_code == 2'h1 && i_rx_count < 5'h08) |=> !o_rx_int)
    else $error("Receive interrupt raised below eight bytes with large FIFO.");
  AST_RX_DEFAULT: assert property (@(posedge i_clock) disable iff (!i_rstn) // R3
    (rx_code == 2'h0) |=> (o_rx_int == ($past(i_rx_count) != 5'h00)))
    else $error("Default receive threshold is not one byte.");
  AST_TX_SMALL_SIX: assert property (@(posedge i_clock) disable iff (!i_rstn) // R4
    (tx_en_reg && !deep && tx_code == 2'h2 && i_tx_count <= 5'h02) |=> o_tx_int)
    else $error("Transmit interrupt missing at six free positions.");
  AST_TX_DEFAULT: assert property (@(posedge i_clock) disable iff (!i_rstn) // R6
    (tx_code == 2'h0 && i_tx_count != 5'h00) |=> !o_tx_int)
    else $error("Default transmit interrupt held with a byte loaded.");
  AST_PTR_ADVANCE: assert property (@(posedge i_clock) disable iff (!i_rstn) // R9
    (mode_wr && !cmd_wr && ptr_reg == UMC_PTR_MR1) |=> (ptr_reg == UMC_PTR_MR2))
    else $error("Mode pointer did not move on to mode_reg_2.");
  AST_ERR_STICKY: assert property (@(posedge i_clock) disable iff (!i_rstn) // R11
    (err_acc_reg != 3'h0 && !err_clear) |=> (err_acc_reg != 3'h0))
    else $error("Accumulated error status lost without a clear.");
  AST_RTS_FLOW: assert property (@(posedge i_clock) disable iff (!i_rstn) // R12
    (mode1_reg[MR1_RXRTS_BIT] && i_rx_start && rx_full && !cmd_rx_rst) |=> o_request_to_send_out_n)
    else $error("Request-to-send still asserted on start bit with FIFO full.");
  AST_OVERRUN: assert property (@(posedge i_clock) disable iff (!i_rstn) // R13
    (i_rx_start && rx_full && beyond_reg) |=> (o_rx_discard && overrun_reg))
    else $error("Character beyond capacity was not discarded.");
  AST_CTS_BLOCK: assert property (@(posedge i_clock) disable iff (!i_rstn) // R20
    (mode2_reg[MR2_CTS_BIT] && cts_sync_reg) |=> !o_tx_send_ok)
    else $error("Transmit allowed while clear-to-send is high.");
  AST_TURNAROUND: assert property (@(posedge i_clock) disable iff (!i_rstn) // R21
    (timer_done && auto_rts && !set_wr) |=> !o_output_reg[0])
    else $error("Output bit zero not cleared after line turnaround.");

endmodule

// ### umc_mode_config_tb.sv
// Self-checking bench for the mode configuration block.
`timescale 1ns/1ns
module umc_mode_config_tb import umc_pkg::*;;
  localparam int BITC = 4;
  logic i_clock, i_rstn, i_wr_en, i_rd_en, rd_now, o_rx_int, o_tx_int, rts_n, send_ok, discard;
  logic o_parity_on, o_parity_type, o_fifo_16, hit;
  logic rx_en, tx_en, rx_rst, tx_rst;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_output_reg;
  logic [1:0] o_char_bits, o_parity_mode, o_channel_mode, o_baud_sel;
  logic [5:0] o_stop_sixteenths;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic rd_d1 = 1'b0;
  logic [7:0] bauds[3] = '{8'h00, 8'h01, 8'h04};
  int rtab[8] = '{1, 6, 4, 8, 1, 8, 12, 16};
  int ttab[8] = '{8, 4, 6, 1, 16, 8, 12, 1};
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 36434;
  umc_path_model pm (.i_clock(i_clock), .o_rx_count(), .o_tx_count(), .o_tx_idle(), .o_rx_start(),
    .o_top_advance(), .o_fe(), .o_pe(), .o_brk(), .o_cts_n());
  umc_mode_config #(.BIT_CYCLES_P(BITC)) dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rx_count(pm.o_rx_count),
    .i_tx_count(pm.o_tx_count), .i_tx_idle(pm.o_tx_idle), .i_rx_start(pm.o_rx_start),
    .i_top_advance(pm.o_top_advance), .i_top_framing_err(pm.o_fe), .i_top_parity_err(pm.o_pe),
    .i_top_break(pm.o_brk), .i_clear_to_send_in_n(pm.o_cts_n), .o_rx_int(o_rx_int), .o_tx_int(o_tx_int),
    .o_request_to_send_out_n(rts_n), .o_tx_send_ok(send_ok), .o_rx_discard(discard),
    .o_output_reg(o_output_reg), .o_rx_enable(rx_en), .o_tx_enable(tx_en),
    .o_rx_reset(rx_rst), .o_tx_reset(tx_rst),
    .o_char_bits(o_char_bits), .o_parity_mode(o_parity_mode), .o_parity_type(o_parity_type),
    .o_parity_on(o_parity_on), .o_stop_sixteenths(o_stop_sixteenths), .o_channel_mode(o_channel_mode),
    .o_baud_sel(o_baud_sel), .o_fifo_16(o_fifo_16));
  // ----------------------------------------------------------------
  // Checking and register tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    tick(1);
    i_wr_en = 1'b0;
    tick(1);
  endtask
  // The expected byte goes on the queue with a mask of the bits that matter.
  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
    exp_q.push_back({m, d});
    i_addr = a;
    i_rd_en = 1'b1;
    tick(1);
    i_rd_en = 1'b0;
    tick(1);
  endtask
  task automatic cfg(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] m2);
    wr(ADDR_COMMAND, {CMD_PTR_MR0, 4'h0});
    wr(ADDR_MODE, m0);
    wr(ADDR_MODE, m1);
    wr(ADDR_MODE, m2);
  endtask
  // Read data is registered on the read edge and holds until the next read.
  always @(posedge i_clock) begin
    rd_now = i_rd_en;
    if (rd_d1) begin
      #2;
      e = exp_q.pop_front();
      chk(o_rdata & e[15:8], e[7:0] & e[15:8]);
    end
    rd_d1 = rd_now;
  end
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int dep, rt, tt, n, s, w;
    i_rstn = 1'b0;
    i_addr = ADDR_MODE;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_wdata = 8'h00;
    repeat (6) @(posedge i_clock);
    #1 i_rstn = 1'b1;
    tick(1);
    chk(o_tx_int, 1'b0);
    chk(o_rx_int, 1'b0);
    rd(ADDR_MODE, MODE_REG_RESET, 8'hFF);
    rd(ADDR_MODE, MODE_REG_RESET, 8'hFF);
    rd(4'h5, 8'h00, 8'hFF);
    wr(ADDR_COMMAND, 8'h05);
    chk({rx_en, tx_en}, 8'h03);
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 4; c++) begin
        cfg({1'b0, c[1], c[1:0], d[0], 3'h0}, {1'b0, c[0], 6'h03}, 8'h00);
        chk(o_fifo_16, d[0]);
        dep = d ? 16 : 8;
        rt = rtab[d * 4 + c];
        tt = ttab[d * 4 + c];
        for (int k = 0; k < 6; k++) begin
          n = (k == 0) ? rt - 1 : (k == 1) ? rt : (k == 2) ? dep - tt : (k == 3) ? dep - tt + 1
            : $unsigned($random(seed)) % (dep + 1);
          pm.lvl(n[4:0], n[4:0]);
          tick(2);
          chk(o_rx_int, n >= rt);
          chk(o_tx_int, dep - n >= tt);
        end
      end
    end
    for (int i = 0; i < 8; i++) begin
      s = (i * 5) % 16;
      cfg(bauds[i % 3], {3'h0, i[1:0], i[2], i[1:0]}, {i[2:1], 2'h0, s[3:0]});
      chk(o_baud_sel, i % 3);
      chk(o_char_bits, i[1:0]);
      chk(o_parity_mode, i[1:0]);
      chk(o_parity_on, !i[1]);
      chk(o_parity_type, i[2]);
      chk(o_channel_mode, i[2:1]);
      chk(o_stop_sixteenths, s < 8 ? 9 + s + (i[1:0] == 0 ? 8 : 0) : 17 + s);
    end
    wr(ADDR_COMMAND, {CMD_PTR_MR1, 4'h0});
    rd(ADDR_MODE, 8'h1F, 8'hFF);
    rd(ADDR_MODE, 8'hC3, 8'hFF);
    rd(ADDR_MODE, 8'hC3, 8'hFF);
    cfg(8'h00, 8'h23, 8'h00);
    pm.new_top(3'h1);
    pm.new_top(3'h0);
    rd(ADDR_STATUS, 8'h20, 8'hE0);
    wr(ADDR_COMMAND, {CMD_ERR_RESET, 4'h0});
    rd(ADDR_STATUS, 8'h00, 8'hE0);
    cfg(8'h00, 8'h03, 8'h00);
    pm.new_top(3'h2);
    rd(ADDR_STATUS, 8'h40, 8'hE0);
    pm.new_top(3'h0);
    cfg(8'h00, 8'h83, 8'h00);
    wr(ADDR_OUT_SET, 8'h01);
    chk(rts_n, 1'b0);
    pm.lvl(5'h08, 5'h00);
    tick(1);
    pm.start_bit();
    tick(1);
    chk(rts_n, 1'b1);
    chk(o_output_reg, 8'h01);
    hit = 1'b0;
    pm.start_bit();
    for (int k = 0; k < 4; k++) begin
      if (discard === 1'b1) hit = 1'b1;
      tick(1);
    end
    chk(hit, 1'b1);
    if (hit !== 1'b1) end_sim();
    rd(ADDR_STATUS, 8'h10, 8'h10);
    pm.lvl(5'h07, 5'h00);
    tick(2);
    chk(rts_n, 1'b0);
    wr(ADDR_COMMAND, {CMD_ERR_RESET, 4'h0});
    cfg(8'h00, 8'h00, 8'h10);
    pm.o_cts_n = 1'b1;
    tick(4);
    chk(send_ok, 1'b0);
    pm.o_cts_n = 1'b0;
    tick(4);
    chk(send_ok, 1'b1);
    cfg(8'h00, 8'h00, 8'h20);
    wr(ADDR_COMMAND, 8'h08);
    pm.o_tx_idle = 1'b1;
    w = 0;
    while (o_output_reg[0] === 1'b1 && w < 40) begin
      tick(1);
      w++;
    end
    chk(w >= BITC && w < 40, 1'b1);
    if (w == 40) end_sim();
    chk(rts_n, 1'b1);
    // Two commands back to back: the strobe stays high and only the data moves.
    i_addr = ADDR_COMMAND;
    i_wdata = {CMD_RX_RESET, 4'h4};
    i_wr_en = 1'b1;
    tick(1);
    chk({rx_rst, tx_rst, rx_en, tx_en}, 8'h09);
    i_wdata = {CMD_TX_RESET, 4'h2};
    tick(1);
    i_wr_en = 1'b0;
    chk({rx_rst, tx_rst, rx_en, tx_en}, 8'h04);
    tick(3);
    end_sim();
  end
endmodule

// ### umc_path_model.sv
// Behavioural data path beside the mode block: FIFO levels, line events and top-of-FIFO status.
`timescale 1ns/1ns
module umc_path_model (
  // Clock
  input wire logic i_clock,
  // Data path state
  output logic [4:0] o_rx_count,
  output logic [4:0] o_tx_count,
  output logic o_tx_idle,
  output logic o_rx_start,
  output logic o_top_advance,
  output logic o_fe,
  output logic o_pe,
  output logic o_brk,
  output logic o_cts_n
);
  initial begin
    {o_rx_count, o_tx_count} = 10'h000;
    {o_tx_idle, o_rx_start, o_top_advance, o_fe, o_pe, o_brk} = 6'h00;
    o_cts_n = 1'b0;
  end
  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  // Events are one clock wide; the caller starts them just after an edge.
  task automatic lvl(input logic [4:0] r, input logic [4:0] t);
    o_rx_count = r;
    o_tx_count = t;
  endtask
  task automatic start_bit();
    o_rx_start = 1'b1;
    @(posedge i_clock);
    #1 o_rx_start = 1'b0;
  endtask
  // The status stays with the character until the next one reaches the top.
  task automatic new_top(input logic [2:0] st);
    {o_brk, o_fe, o_pe} = st;
    o_top_advance = 1'b1;
    @(posedge i_clock);
    #1 o_top_advance = 1'b0;
  endtask
endmodule

// ### umc_pkg.sv
// Constants and types shared by the mode configuration block.
package umc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS = 104167;
  // A least time, so the count rounds up.
  localparam int BIT_CYCLES = (BIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_OUT_SET = 4'hE;
  localparam logic [3:0] ADDR_OUT_CLR = 4'hF;

  // ----------------------------------------------------------------
  // Channel commands in the upper nibble of command_reg, enable and disable bits in the lower nibble
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_PTR_MR1 = 4'h1;
  localparam logic [3:0] CMD_RX_RESET = 4'h2;
  localparam logic [3:0] CMD_TX_RESET = 4'h3;
  localparam logic [3:0] CMD_ERR_RESET = 4'h4;
  localparam logic [3:0] CMD_PTR_MR0 = 4'hB;
  localparam int CMD_RX_EN_BIT = 0;
  localparam int CMD_RX_DIS_BIT = 1;
  localparam int CMD_TX_EN_BIT = 2;
  localparam int CMD_TX_DIS_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_REG_RESET = 8'h00;
  localparam logic [7:0] OUT_REG_RESET = 8'h00;
  localparam int MR0_RXINT_BIT = 6;
  localparam int MR0_TXINT_LO = 4;
  localparam int MR0_FIFO_BIT = 3;
  localparam int MR0_BAUD_LO = 0;
  localparam int MR1_RXRTS_BIT = 7;
  localparam int MR1_RXINT_BIT = 6;
  localparam int MR1_ERRMODE_BIT = 5;
  localparam int MR1_PAR_LO = 3;
  localparam int MR1_PTYPE_BIT = 2;
  localparam int MR1_LEN_LO = 0;
  localparam int MR2_CHMODE_LO = 6;
  localparam int MR2_TXRTS_BIT = 5;
  localparam int MR2_CTS_BIT = 4;
  localparam int MR2_STOP_LO = 0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [4:0] DEPTH_SMALL = 5'h08;
  localparam logic [4:0] DEPTH_LARGE = 5'h10;
  localparam logic [1:0] PAR_WITH = 2'h0;
  localparam logic [1:0] PAR_FORCE = 2'h1;
  localparam logic [1:0] LEN_FIVE = 2'h0;
  localparam logic [2:0] BAUD_NORMAL = 3'h0;
  localparam logic [2:0] BAUD_EXT1 = 3'h1;
  localparam logic [2:0] BAUD_EXT2 = 3'h4;
  localparam logic [1:0] BAUD_SEL_NORMAL = 2'h0;
  localparam logic [1:0] BAUD_SEL_EXT1 = 2'h1;
  localparam logic [1:0] BAUD_SEL_EXT2 = 2'h2;
  localparam logic [5:0] STOP_BASE_SHORT = 6'h09;
  localparam logic [5:0] STOP_BASE_LONG = 6'h11;
  localparam logic [5:0] STOP_HALF_BIT = 6'h08;

  typedef enum logic [1:0] {UMC_PTR_MR0, UMC_PTR_MR1, UMC_PTR_MR2} umc_ptr_t;

endpackage
